/* rtl/vic_top.sv */
// Purpose: vectored interrupt controller, one request line to the core
// Assumes: peripheral events are one-cycle pulses synchronous to CLOCK
// Notes: flags set by hardware, cleared by software; set wins over clear
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - all requests merge into one core request
// - seven levels, fixed order inside a level
// - each source gets its own vector
// - entry and return take fixed cycles
// - primary table at 000004h, 126 vectors
// - vector entries are 24-bit fetch addresses
// - lower vector number wins natural priority
// - 21 requests, 4 traps; rest reserved
// - select bit moves all fetches to alternate
// - alternate entry is primary plus 0x100
// - traps 0..7 at 0x04..0x12, stepping two
// - request n is vector n+8, 0x14+2n
// - low request numbers map to named peripherals
// - higher request numbers map; rest reserved
// - reset bypasses controller, start at zero
// - reset values independent of reset type
// - flags set by source, cleared by software
// - three-bit level per source, zero never
// - core level 7 or trap level blocks
// - pending vector and level are readable
module vic_top #(
   parameter int N = vic_pkg::NUM_IRQ
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // event inputs from peripherals and traps
   input wire logic [N-1:0] IRQ_EVENT,
   input wire logic [7:0] TRAP_EVENT,
   // software control of flags, enables and levels
   input wire logic [N-1:0] FLAG_CLEAR,
   input wire logic [7:0] TRAP_CLEAR,
   input wire logic [N-1:0] ENABLE,
   input wire logic PRIO_WRITE,
   input wire logic [6:0] PRIO_INDEX,
   input wire logic [2:0] PRIO_VALUE,
   input wire logic ALT_TABLE_SELECT,
   input wire logic [3:0] CPU_PRIORITY_LEVEL,
   // core handshake
   input wire logic CORE_ACK,
   input wire logic CORE_RETURN,
   // core outputs
   output logic CPU_REQUEST,
   output logic [23:0] FETCH_ADDR,
   output logic FETCH_VALID,
   output logic RETURN_DONE,
   output logic [23:0] RESET_VECTOR,
   // status
   output logic [6:0] PENDING_VECTOR_FIELD,
   output logic [3:0] PENDING_LEVEL_FIELD,
   output logic [N-1:0] FLAGS,
   output logic [7:0] TRAP_FLAGS
);
   // flag and level storage
   logic [N-1:0] flag_q, flag_d;
   logic [7:0] trap_q, trap_d;
   logic [N*3-1:0] prio_q, prio_d;
   // user winner and trap winner
   logic u_found;
   logic [6:0] u_idx;
   logic [2:0] u_lvl;
   logic t_found;
   logic [2:0] t_idx;
   vic_pkg::vic_pend_t pend;
   logic [N-1:0] act;
   logic [23:0] vaddr;
   // sequencer
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ENTER = 3'b010,
      ST_RETURN = 3'b100
   } vic_state_t;
   vic_state_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   vic_pkg::vic_pend_t pend_q, pend_d;
   logic req_q, req_d;
   logic [23:0] addr_q, addr_d;
   logic fv_q, fv_d;
   logic rd_q, rd_d;

   // flags: hardware set beats software clear; unused slots never set
   // only the named request numbers take events, the rest stay clear
   always_comb begin
      flag_d = (flag_q & ~FLAG_CLEAR) | (IRQ_EVENT & vic_pkg::IRQ_IMPL_MASK);
      trap_d = (trap_q & ~TRAP_CLEAR) | (TRAP_EVENT & vic_pkg::TRAP_IMPL_MASK);
      prio_d = prio_q;
      if (PRIO_WRITE && (int'(PRIO_INDEX) < N)) begin
         prio_d[PRIO_INDEX*3 +: 3] = PRIO_VALUE;
      end
   end

   // one reset value regardless of why reset happened
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         flag_q <= '0;
         trap_q <= 8'h00;
         prio_q <= {N{vic_pkg::RST_PRIO}};
      end else begin
         flag_q <= flag_d;
         trap_q <= trap_d;
         prio_q <= prio_d;
      end
   end

   assign act = flag_q & ENABLE;

   // user arbitration: level first, lowest number breaks a tie
   vic_arbiter #(.N(N)) u_arb (
      .act(act),
      .prio(prio_q),
      .found(u_found),
      .idx(u_idx),
      .lvl(u_lvl)
   );

   // trap pick and overall winner; traps outrank any user source
   always_comb begin
      t_found = 1'b0;
      t_idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (trap_q[i]) begin
            t_found = 1'b1;
            t_idx = 3'(i);
         end
      end
      pend = '0;
      if (t_found) begin
         pend.valid = 1'b1;
         pend.vec = {4'h0, t_idx};
         pend.level = vic_pkg::LEVEL_TRAP;
      end else if (u_found && !CPU_PRIORITY_LEVEL[3]
                   && ({1'b0, u_lvl} > CPU_PRIORITY_LEVEL)) begin
         pend.valid = 1'b1;
         pend.vec = u_idx + vic_pkg::IRQ_VEC_OFFSET;
         pend.level = {1'b0, u_lvl};
      end
   end

   // table address for the winner, primary or alternate
   // built from the registered winner, so the address matches the request the core saw
   vic_vecaddr u_addr (
      .vec(pend_q.vec),
      .alt(ALT_TABLE_SELECT),
      .addr(vaddr)
   );

   // sequencer: fixed-length entry and return, whatever the source
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      pend_d = pend_q;
      req_d = 1'b0;
      addr_d = addr_q;
      fv_d = 1'b0;
      rd_d = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            pend_d = pend;
            req_d = pend.valid;
            if (req_q && CORE_ACK) begin
               st_d = ST_ENTER;
               cnt_d = 3'(vic_pkg::ENTRY_CYCLES - 1);
               addr_d = vaddr;
               req_d = 1'b0;
            end else if (CORE_RETURN) begin
               st_d = ST_RETURN;
               cnt_d = 3'(vic_pkg::RETURN_CYCLES - 1);
               req_d = 1'b0; // no request shown while the return runs
            end
         end
         ST_ENTER: begin
            // counter wraps once on the way out; idle reloads it before use
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
               fv_d = 1'b1;
            end
            if (cnt_q == 3'h0) begin
               st_d = ST_IDLE;
            end
         end
         ST_RETURN: begin
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
               rd_d = 1'b1;
            end
            if (cnt_q == 3'h0) begin
               st_d = ST_IDLE;
            end
         end
      endcase
   end

   // controller stays idle through reset; the core starts at zero alone
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         st_q <= ST_IDLE;
         cnt_q <= 3'h0;
         pend_q <= '0;
         req_q <= 1'b0;
         addr_q <= vic_pkg::RESET_ADDR;
         fv_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         pend_q <= pend_d;
         req_q <= req_d;
         addr_q <= addr_d;
         fv_q <= fv_d;
         rd_q <= rd_d;
      end
   end

   // outputs straight from flops; the reset vector is a constant
   assign CPU_REQUEST = req_q;
   assign FETCH_ADDR = addr_q;
   assign FETCH_VALID = fv_q;
   assign RETURN_DONE = rd_q;
   assign PENDING_VECTOR_FIELD = pend_q.vec;
   assign PENDING_LEVEL_FIELD = pend_q.level;
   assign FLAGS = flag_q;
   assign TRAP_FLAGS = trap_q;
   assign RESET_VECTOR = vic_pkg::RESET_ADDR;

   // assertions
   flag_set_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (IRQ_EVENT[0]) |=> FLAGS[0])
      else $error("flag not set by event");
   trap_set_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (TRAP_EVENT[1]) |=> TRAP_FLAGS[1])
      else $error("trap flag not set");
   rsvd_flag_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      !FLAGS[4] && !TRAP_FLAGS[0])
      else $error("reserved slot flagged");
   entry_lat_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_IDLE && CORE_ACK && CPU_REQUEST) |-> ##5 FETCH_VALID)
      else $error("entry latency wrong");
   ret_lat_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_IDLE && CORE_RETURN && !(CORE_ACK && CPU_REQUEST)) |-> ##3 RETURN_DONE)
      else $error("return latency wrong");
   addr_map_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      FETCH_VALID |-> (FETCH_ADDR[0] == 1'b0) && (FETCH_ADDR < vic_pkg::CODE_START))
      else $error("fetch address outside tables");
   level_gate_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (pend.valid && pend.level < vic_pkg::LEVEL_TRAP) |-> (pend.level > CPU_PRIORITY_LEVEL))
      else $error("request not above core level");
   blocked_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CPU_PRIORITY_LEVEL >= 4'h7 && trap_q == 8'h00) |-> !pend.valid)
      else $error("core level did not block");
   vec_map_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (pend.valid && !t_found) |-> (pend.vec == u_idx + 7'h08))
      else $error("request vector mapping wrong");
   // handshake shape: request drops while busy, strobes last one cycle
   req_busy_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q != ST_IDLE) |-> !CPU_REQUEST)
      else $error("request raised while busy");
   ack_drop_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_IDLE && CORE_ACK && CPU_REQUEST) |=> !CPU_REQUEST)
      else $error("request held after acknowledge");
   fetch_pulse_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      FETCH_VALID |=> !FETCH_VALID)
      else $error("fetch strobe longer than one cycle");
   ret_pulse_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      RETURN_DONE |=> !RETURN_DONE)
      else $error("return strobe longer than one cycle");
   enter_cnt_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_ENTER) |-> (cnt_q <= 3'(vic_pkg::ENTRY_CYCLES - 1)))
      else $error("entry counter out of range");
   return_cnt_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_RETURN) |-> (cnt_q <= 3'(vic_pkg::RETURN_CYCLES - 1)))
      else $error("return counter out of range");
   // table choice is taken at the edge where the core accepts
   alt_fetch_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_IDLE && CORE_ACK && CPU_REQUEST && ALT_TABLE_SELECT)
      |=> (FETCH_ADDR >= vic_pkg::ALT_OFFSET + vic_pkg::PRIMARY_BASE))
      else $error("alternate table not used");
   prim_fetch_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (st_q == ST_IDLE && CORE_ACK && CPU_REQUEST && !ALT_TABLE_SELECT)
      |=> (FETCH_ADDR < vic_pkg::ALT_OFFSET))
      else $error("primary table not used");
   // traps always win; user levels never zero, unnamed flags stay clear, pending level set while requesting
   trap_first_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (trap_q != 8'h00) |-> (pend.valid && pend.vec < vic_pkg::IRQ_VEC_OFFSET))
      else $error("trap did not win");
   level_zero_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      u_found |-> (u_lvl != 3'h0))
      else $error("level zero source picked");
   used_flag_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      ((FLAGS & ~vic_pkg::IRQ_IMPL_MASK) == '0))
      else $error("unnamed request number flagged");
   pend_field_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CPU_REQUEST |-> (PENDING_LEVEL_FIELD != 4'h0))
      else $error("pending level empty while requesting");
   // scenarios worth seeing at least once
   enter_c: cover property (@(posedge CLOCK) disable iff (!RESETN) FETCH_VALID);
   return_c: cover property (@(posedge CLOCK) disable iff (!RESETN) RETURN_DONE);
   alt_c: cover property (@(posedge CLOCK) disable iff (!RESETN)
      FETCH_VALID && FETCH_ADDR >= vic_pkg::ALT_OFFSET);
   trap_c: cover property (@(posedge CLOCK) disable iff (!RESETN) t_found && u_found);
   blocked_c: cover property (@(posedge CLOCK) disable iff (!RESETN) u_found && !pend.valid);
endmodule
`default_nettype wire

/* common/vic_pkg.sv */
// Purpose: shared constants and types of the vectored interrupt controller
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes: vector addresses are program word addresses, two per entry
package vic_pkg;
   // source counts
   localparam int NUM_IRQ = 118;
   localparam int NUM_TRAP = 8;
   localparam int NUM_USER_USED = 21;
   localparam int NUM_TRAP_USED = 4;
   // table layout
   localparam logic [23:0] RESET_ADDR = 24'h00_0000;
   localparam logic [23:0] PRIMARY_BASE = 24'h00_0004;
   localparam logic [23:0] IRQ_BASE = 24'h00_0014;
   localparam logic [23:0] ALT_OFFSET = 24'h00_0100;
   localparam logic [23:0] CODE_START = 24'h00_0200;
   localparam logic [6:0] IRQ_VEC_OFFSET = 7'h08;
   // fixed entry and return latencies in clocks, same for every source
   localparam int ENTRY_CYCLES = 5;
   localparam int RETURN_CYCLES = 3;
   // trap slot numbers
   localparam int TRAP_OSC_FAIL = 1;
   localparam int TRAP_ADDR_ERR = 2;
   localparam int TRAP_STACK_ERR = 3;
   localparam int TRAP_MATH_ERR = 4;
   localparam logic [7:0] TRAP_IMPL_MASK = 8'h1E;
   // request numbers in use
   localparam logic [117:0] IRQ_IMPL_MASK =
      118'h0 | (118'h1 << 65) | (118'h1 << 29) | (118'h1 << 23) | (118'h1 << 22)
      | (118'h1 << 20) | (118'h1 << 19) | (118'h1 << 17) | (118'h1 << 16)
      | 118'h3FEF;
   // reset values, the same for every kind of reset; then the trap level
   localparam logic [2:0] RST_PRIO = 3'h4;
   localparam logic [3:0] RST_CPU_LEVEL = 4'h0;
   localparam logic [3:0] LEVEL_TRAP = 4'h8;

   // pending winner as handed to the core
   typedef struct packed {
      logic valid;
      logic [6:0] vec;
      logic [3:0] level;
   } vic_pend_t;
endpackage

/* rtl/vic_arbiter.sv */
// Purpose: picks the winning user request by level, then by lowest number
// Assumes: inputs stable within a clock
// Notes: purely combinational; the top registers its result
`timescale 1ns/1ns
`default_nettype none
module vic_arbiter #(
   parameter int N = 118
) (
   // per-source inputs
   input wire logic [N-1:0] act,
   input wire logic [N*3-1:0] prio,
   // result
   output logic found,
   output logic [6:0] idx,
   output logic [2:0] lvl
);
   // scan downward so the lowest number wins a tie
   always_comb begin
      found = 1'b0;
      idx = 7'h00;
      lvl = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (act[i] && (prio[i*3 +: 3] >= lvl) && (prio[i*3 +: 3] != 3'h0)) begin
            found = 1'b1;
            idx = 7'(i);
            lvl = prio[i*3 +: 3];
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/vic_vecaddr.sv */
// Purpose: turns a vector number into a 24-bit fetch address
// Assumes: vector 0..125
// Notes: alternate table sits one page above the primary one
`timescale 1ns/1ns
`default_nettype none
module vic_vecaddr (
   // selection
   input wire logic [6:0] vec,
   input wire logic alt,
   // address
   output logic [23:0] addr
);
   // two words per entry starting at the primary base
   always_comb begin
      addr = vic_pkg::PRIMARY_BASE + {16'h0000, vec, 1'b0};
      if (alt) begin
         addr = addr + vic_pkg::ALT_OFFSET;
      end
   end
endmodule
`default_nettype wire

/* testbench/vic_core_model.sv */
// Purpose: behavioural core that takes interrupts from the controller
// Assumes: acks are held until the controller samples them; returns are one-cycle pulses
// Notes: wait_cycles paces it slow or prompt; it measures both latencies
`timescale 1ns/1ns
`default_nettype none
module vic_core_model (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // controller side
   input wire logic cpu_request,
   input wire logic fetch_valid,
   input wire logic return_done,
   output logic core_ack,
   output logic core_return,
   // pacing and measured latencies
   input wire logic [3:0] wait_cycles,
   output logic [7:0] entry_count,
   output logic [7:0] return_count
);
   logic [2:0] st; // 0 wait, 1 ack, 2 entry, 3 service, 4 return
   logic [3:0] dly; // pacing count
   logic [7:0] cnt; // latency count
   // one process; never acks while in service, so no ack meets a return
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         // core restarts at the reset address where its jump sits
         st <= 3'h0;
         dly <= 4'h0;
         cnt <= 8'h00;
         core_ack <= 1'b0;
         core_return <= 1'b0;
         entry_count <= 8'h00;
         return_count <= 8'h00;
      end else begin
         core_return <= 1'b0;
         case (st)
            3'h0: if (cpu_request) begin
               if (dly >= wait_cycles) begin
                  core_ack <= 1'b1;
                  st <= 3'h1;
               end else dly <= dly + 4'h1;
            end
            // ack held until the controller sees it with its request
            3'h1: if (cpu_request) begin
               core_ack <= 1'b0;
               cnt <= 8'h01;
               st <= 3'h2;
            end
            3'h2: if (fetch_valid) begin
               entry_count <= cnt;
               dly <= 4'h0;
               st <= 3'h3;
            end else cnt <= cnt + 8'h01;
            3'h3: if (dly >= wait_cycles) begin
               core_return <= 1'b1;
               cnt <= 8'h00;
               st <= 3'h4;
            end else dly <= dly + 4'h1;
            default: if (return_done) begin
               return_count <= cnt;
               dly <= 4'h0;
               st <= 3'h0;
            end else cnt <= cnt + 8'h01;
         endcase
      end
   end
endmodule
`default_nettype wire

/* testbench/vectored_interrupt_controller_tb_top.sv */
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: core model acks and returns, paced per test
// Notes: expectations come from the table layout, never from outputs
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_controller_tb_top;
   localparam int N = 118;
   localparam int USED[21] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 19, 20, 22,
      23, 29, 65};
   logic clock, resetn, prio_write, alt_sel, core_ack, core_return;
   logic cpu_request, fetch_valid, return_done;
   logic [N-1:0] irq_event, flag_clear, enable, flags, set;
   logic [7:0] trap_event, trap_clear, trap_flags, ent_cnt, ret_cnt;
   logic [6:0] prio_index, pend_vec;
   logic [2:0] prio_value;
   logic [3:0] cpu_level, pend_lvl, wait_cyc;
   logic [23:0] fetch_addr, reset_vector;
   logic [2:0] pr [N]; // levels the bench expects per source
   int n_mismatch = 0;
   int checks_done = 0;
   int w;
   vic_top #(.N(N)) u_dut (.CLOCK(clock), .RESETN(resetn), .IRQ_EVENT(irq_event),
      .TRAP_EVENT(trap_event), .FLAG_CLEAR(flag_clear), .TRAP_CLEAR(trap_clear),
      .ENABLE(enable), .PRIO_WRITE(prio_write), .PRIO_INDEX(prio_index),
      .PRIO_VALUE(prio_value), .ALT_TABLE_SELECT(alt_sel), .CPU_PRIORITY_LEVEL(cpu_level),
      .CORE_ACK(core_ack), .CORE_RETURN(core_return), .CPU_REQUEST(cpu_request),
      .FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid), .RETURN_DONE(return_done),
      .RESET_VECTOR(reset_vector), .PENDING_VECTOR_FIELD(pend_vec),
      .PENDING_LEVEL_FIELD(pend_lvl), .FLAGS(flags), .TRAP_FLAGS(trap_flags));
   vic_core_model u_core (.clock(clock), .resetn(resetn), .cpu_request(cpu_request),
      .fetch_valid(fetch_valid), .return_done(return_done), .core_ack(core_ack),
      .core_return(core_return), .wait_cycles(wait_cyc), .entry_count(ent_cnt),
      .return_count(ret_cnt));
   // 50 ns clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_reset;
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      foreach (pr[i]) pr[i] = 3'h4;
   endtask
   task automatic fire(input logic [N-1:0] im, input logic [7:0] tm);
      @(posedge clock);
      irq_event <= im;
      trap_event <= tm;
      @(posedge clock);
      irq_event <= '0;
      trap_event <= 8'h00;
   endtask
   task automatic set_prio(input int n, input logic [2:0] v);
      @(posedge clock);
      prio_write <= 1'b1;
      prio_index <= 7'(n);
      prio_value <= v;
      pr[n] = v;
      @(posedge clock);
      prio_write <= 1'b0;
   endtask
   task automatic clear_all;
      @(posedge clock);
      flag_clear <= '1;
      trap_clear <= 8'hFF;
      @(posedge clock);
      flag_clear <= '0;
      trap_clear <= 8'h00;
   endtask
   // expect no request, then drop whatever flags were raised
   task automatic quiet;
      repeat (4) @(negedge clock);
      chk("request", 0, cpu_request);
      clear_all();
   endtask
   // one full entry and return, with address and latencies checked
   task automatic serve(input logic [6:0] vec, input logic [3:0] lvl);
      int k;
      k = 0;
      while (cpu_request !== 1'b1 && k < 20) begin
         @(negedge clock);
         k++;
      end
      chk("request", 1, cpu_request);
      chk("vector", vec, pend_vec);
      chk("level", lvl, pend_lvl);
      k = 0;
      while (fetch_valid !== 1'b1 && k < 40) begin
         @(negedge clock);
         k++;
      end
      chk("fetch valid", 1, fetch_valid);
      chk("fetch", 24'h00_0004 + 24'(vec) * 24'h00_0002 + (alt_sel ? 24'h00_0100 : 24'h00_0000),
         fetch_addr);
      clear_all();
      k = 0;
      while (return_done !== 1'b1 && k < 40) begin
         @(negedge clock);
         k++;
      end
      chk("return done", 1, return_done);
      @(negedge clock);
      chk("entry", vic_pkg::ENTRY_CYCLES, ent_cnt);
      chk("return", vic_pkg::RETURN_CYCLES, ret_cnt);
   endtask
   function automatic int winner(input logic [N-1:0] s);
      int b;
      b = -1;
      for (int i = 0; i < N; i++)
         if (s[i] && {1'b0, pr[i]} > cpu_level && (b < 0 || pr[i] > pr[b])) b = i;
      return b;
   endfunction
   initial begin
      resetn = 1'b0;
      irq_event = '0;
      trap_event = 8'h00;
      flag_clear = '0;
      trap_clear = 8'h00;
      enable = '1;
      prio_write = 1'b0;
      prio_index = 7'h00;
      prio_value = 3'h0;
      alt_sel = 1'b0;
      cpu_level = 4'h0;
      wait_cyc = 4'h0;
      void'($urandom(93));
      do_reset();
      @(negedge clock);
      chk("request", 0, cpu_request);
      chk("reset vector", 0, reset_vector);
      chk("flags", 0, {flags, trap_flags});
      $display("test reset done");
      foreach (USED[k]) begin
         @(posedge clock);
         alt_sel <= 1'($urandom_range(0, 1));
         wait_cyc <= 4'($urandom_range(0, 3));
         fire(118'h1 << USED[k], 8'h00);
         serve(7'(USED[k] + 8), 4'h4);
      end
      $display("test sources done");
      fire((118'h1 << 4) | (118'h1 << 117), 8'h81);
      repeat (4) @(negedge clock);
      chk("flags", 0, {flags, trap_flags});
      chk("request", 0, cpu_request);
      $display("test reserved done");
      @(posedge clock);
      cpu_level <= 4'h7;
      enable[5] <= 1'b0;
      set_prio(3, 3'h7);
      set_prio(6, 3'h0);
      fire(118'h68, 8'h00);
      repeat (6) @(negedge clock);
      chk("request", 0, cpu_request);
      chk("flags", 118'h68, flags);
      @(posedge clock);
      cpu_level <= 4'h0;
      serve(7'h0B, 4'h7);
      enable[5] <= 1'b1;
      $display("test masking done");
      @(posedge clock);
      cpu_level <= 4'hF;
      for (int s = 1; s <= 4; s++) begin
         fire(118'h0, 8'(1 << s));
         @(negedge clock);
         chk("trap flags", 8'(1 << s), trap_flags);
         serve(7'(s), vic_pkg::LEVEL_TRAP);
      end
      @(posedge clock);
      cpu_level <= 4'h0;
      fire(118'h1, 8'h10);
      serve(7'h04, vic_pkg::LEVEL_TRAP);
      $display("test traps done");
      set_prio(3, 3'h6);
      do_reset();
      fire(118'h8, 8'h00);
      serve(7'h0B, 4'h4);
      $display("test rereset done");
      for (int i = 0; i < 40; i++) begin
         set = '0;
         for (int j = 0; j < 3; j++) begin
            w = USED[$urandom_range(0, 20)];
            set[w] = 1'b1;
            set_prio(w, (i % 2) ? 3'($urandom_range(1, 7)) : 3'($urandom_range(1, 2)));
         end
         @(posedge clock);
         cpu_level <= 4'($urandom_range(0, 6));
         wait_cyc <= 4'($urandom_range(0, 5));
         fire(set, 8'h00);
         w = winner(set);
         if (w < 0) quiet();
         else serve(7'(w + 8), {1'b0, pr[w]});
      end
      $display("test random done");
      results();
   end
   // hang guard, far beyond the expected run
   initial begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      results();
   end
endmodule
`default_nettype wire
